// ### core/dor_output_regs.sv
/*
 * Output command register bank with the output-side logic it steers:
 * line counter alignment, chroma delay, task bit, code substitution,
 * deferred register update and the fixed video pipeline latency.
 * Assumes the host link decoder drives reg_wr/reg_rd with an index,
 * and that video strobes come from logic on clk, qualified by pix_en.
 */
`timescale 1ns/1ps
module dor_output_regs
   import dor_pkg::*;
#(
   parameter int LATENCY = dor_pkg::DOR_LATENCY_CK
)(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_idx,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   output logic      [7:0]            write_now_mask,
   output logic                       deferred_apply,
   output logic                       deferred_pending,
   input  wire logic                  vertical_sync_pin,
   input  wire logic                  embedded_vsync,
   input  wire logic                  use_embedded_sync,
   input  wire logic                  digital_input_mode,
   input  wire logic                  line_start,
   output logic      [DOR_LINE_W-1:0] line_count,
   input  wire logic                  field_odd,
   output logic                       scale_this_field_first,
   output logic                       chroma_bw_boost,
   input  wire logic                  vbi_output,
   output logic                       task_bit,
   input  wire logic                  pix_en,
   input  wire logic [DOR_PIX_W-1:0]  y_in,
   input  wire logic [DOR_PIX_W-1:0]  u_in,
   input  wire logic [DOR_PIX_W-1:0]  v_in,
   input  wire logic                  horizontal_active,
   input  wire logic                  scaled_horizontal_active,
   input  wire logic                  scaled_vertical_active,
   input  wire logic [DOR_PIX_W-1:0]  invalid_luma_code,
   input  wire logic [DOR_PIX_W-1:0]  invalid_u_code,
   input  wire logic [DOR_PIX_W-1:0]  invalid_v_code,
   input  wire logic [DOR_PIX_W-1:0]  unused_luma_code,
   input  wire logic [DOR_PIX_W-1:0]  unused_u_code,
   input  wire logic [DOR_PIX_W-1:0]  unused_v_code,
   output logic      [DOR_PIX_W-1:0]  y_out,
   output logic      [DOR_PIX_W-1:0]  u_out,
   output logic      [DOR_PIX_W-1:0]  v_out
);
   import dor_pkg::*;

   localparam int PW = DOR_PIX_W;
   localparam int SW = 3 * PW + 3;

   logic [7:0]            cmd_e;
   logic [DOR_VSO_W-1:0]  vsync_line_offset;
   logic [7:0]            output_command_f;
   logic [2:0]            vs_sync;
   logic                  vs_level;
   logic                  vs_level_d;
   logic                  emb_d;
   logic                  vsync_start;
   logic [7:0]            member_mask;
   logic [PW-1:0]         u_lag;
   logic [PW-1:0]         v_lag;
   logic [SW-1:0]         pipe [LATENCY-1];
   logic [SW-1:0]         pipe_mid;
   logic [SW-1:0]         pipe_out;
   logic                  deferred_on;

   assign deferred_on = output_command_f[DOR_BIT_DEFERRED];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cmd_e             <= DOR_RST_CMD_E;
         vsync_line_offset <= DOR_RST_VSYNC_OFS[DOR_VSO_W-1:0];
         output_command_f  <= DOR_RST_CMD_F;
      end
      else if (reg_wr)
      begin
         // Own registers are outside the deferred set
         if (reg_idx == DOR_IDX_CMD_E)
            cmd_e <= reg_wdata & DOR_CMD_E_MASK;
         if (reg_idx == DOR_IDX_VSYNC_OFS)
            vsync_line_offset <= reg_wdata[DOR_VSO_W-1:0];
         if (reg_idx == DOR_IDX_CMD_F)
            output_command_f <= reg_wdata & DOR_CMD_F_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
         reg_rdata <= DOR_READ_ZERO;
      else if (reg_rd)
      begin
         unique case (reg_idx)
            DOR_IDX_CMD_E:     reg_rdata <= cmd_e;
            DOR_IDX_VSYNC_OFS: reg_rdata <= {{(8-DOR_VSO_W){1'b0}}, vsync_line_offset};
            DOR_IDX_CMD_F:     reg_rdata <= output_command_f;
            default:           reg_rdata <= DOR_READ_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Vertical sync detection
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         vs_sync    <= 3'h0;
         vs_level   <= 1'b0;
         vs_level_d <= 1'b0;
         emb_d      <= 1'b0;
      end
      else
      begin
         vs_sync <= {vs_sync[1:0], vertical_sync_pin};
         if (vs_sync[1] == vs_sync[2])
            vs_level <= vs_sync[2];
         vs_level_d <= vs_level;
         emb_d      <= embedded_vsync;
      end
   end

   assign vsync_start = use_embedded_sync ? (embedded_vsync && !emb_d) : (vs_level && !vs_level_d);

   // ----------------------------------------------------------------
   // Line counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
         line_count <= DOR_LINE_ZERO;
      else if (vsync_start)
         line_count <= digital_input_mode
                       ? {{(DOR_LINE_W-DOR_VSO_W){1'b0}}, vsync_line_offset}
                       : DOR_LINE_ZERO;
      else if (line_start)
         line_count <= line_count + DOR_LINE_ONE;
   end

   // ----------------------------------------------------------------
   // Deferred update
   // ----------------------------------------------------------------
   always_comb
   begin
      member_mask = DOR_MASK_NONE;
      if (reg_idx == DOR_DEF_IDX_A)
         member_mask = DOR_MASK_ALL;
      else if (reg_idx >= DOR_DEF_IDX_LO && reg_idx <= DOR_DEF_IDX_HI)
         member_mask = DOR_MASK_ALL;
      else if (reg_idx == DOR_DEF_IDX_B)
         member_mask = DOR_DEF_MASK_B;
      else if (reg_idx == DOR_DEF_IDX_C)
         member_mask = DOR_DEF_MASK_C;
   end

   assign write_now_mask = deferred_on ? ~member_mask : DOR_MASK_ALL;
   assign deferred_apply = deferred_pending && vsync_start;

   always_ff @(posedge clk)
   begin
      if (!rstn)
         deferred_pending <= 1'b0;
      else if (reg_wr && deferred_on && member_mask != DOR_MASK_NONE)
         deferred_pending <= 1'b1;
      else if (vsync_start)
         deferred_pending <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Field, bandwidth and task bit controls
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         scale_this_field_first <= 1'b0;
         chroma_bw_boost        <= 1'b0;
         task_bit               <= 1'b1;
      end
      else
      begin
         scale_this_field_first <= (field_odd == cmd_e[DOR_BIT_FIRST_FIELD]);
         chroma_bw_boost        <= output_command_f[DOR_BIT_BW_BOOST];
         task_bit <= !(output_command_f[DOR_BIT_TASK_SEL] && vbi_output);
      end
   end

   // ----------------------------------------------------------------
   // Chroma delay and fixed latency pipeline
   // ----------------------------------------------------------------
   // Lag stage stands in for the last chroma pipe stage
   dor_chroma_lag #(.W(PW)) dor_chroma_lag_i (
      .clk    (clk),
      .rstn   (rstn),
      .pix_en (pix_en),
      .lag_en (output_command_f[DOR_BIT_DLY_EN]),
      .lag_u  (output_command_f[DOR_BIT_DLY_PICK]),
      .u_in   (pipe_mid[3+PW +: PW]),
      .v_in   (pipe_mid[3 +: PW]),
      .u_out  (u_lag),
      .v_out  (v_lag)
   );

   always_ff @(posedge clk)
   begin
      if (!rstn)
         pipe <= '{default: '0};
      else if (pix_en)
      begin
         pipe[0] <= {y_in, u_in, v_in, horizontal_active,
                     scaled_horizontal_active, scaled_vertical_active};
         for (int i = 1; i < LATENCY-1; i++)
            pipe[i] <= pipe[i-1];
      end
   end

   assign pipe_mid = pipe[LATENCY-3];
   assign pipe_out = pipe[LATENCY-2];

   // ----------------------------------------------------------------
   // Output code substitution
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         y_out <= '0;
         u_out <= '0;
         v_out <= '0;
      end
      else if (pix_en)
      begin
         if (!pipe_out[2])
         begin
            y_out <= unused_luma_code;
            u_out <= unused_u_code;
            v_out <= unused_v_code;
         end
         else if (!pipe_out[1] || (output_command_f[DOR_BIT_INV_DROP] && !pipe_out[0]))
         begin
            y_out <= invalid_luma_code;
            u_out <= invalid_u_code;
            v_out <= invalid_v_code;
         end
         else
         begin
            y_out <= pipe_out[SW-1 -: PW];
            u_out <= u_lag;
            v_out <= v_lag;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_line_offset;
      vsync_start && digital_input_mode |=> line_count == DOR_LINE_W'($past(vsync_line_offset));
   endproperty
   a_line_offset: assert property (p_line_offset) else $error("line offset not loaded");

   property p_bw_boost;
      $rose(output_command_f[DOR_BIT_BW_BOOST]) |=> chroma_bw_boost;
   endproperty
   a_bw_boost: assert property (p_bw_boost) else $error("boost not applied");

   property p_task_default;
      !output_command_f[DOR_BIT_TASK_SEL] |=> task_bit;
   endproperty
   a_task_default: assert property (p_task_default) else $error("task bit low in default mode");

   property p_write_now;
      !deferred_on |-> write_now_mask == DOR_MASK_ALL;
   endproperty
   a_write_now: assert property (p_write_now) else $error("write held while not deferred");

   property p_output_command_f_write;
      reg_wr && reg_idx == DOR_IDX_CMD_F |=> output_command_f == ($past(reg_wdata) & DOR_CMD_F_MASK);
   endproperty
   a_output_command_f_write: assert property (p_output_command_f_write) else $error("command write not immediate");

   property p_defer_hold;
      deferred_on && reg_wr && reg_idx == DOR_DEF_IDX_A |-> write_now_mask == DOR_MASK_NONE ##1 deferred_pending;
   endproperty
   a_defer_hold: assert property (p_defer_hold) else $error("deferred write not held");

   property p_field_first;
      rstn |=> scale_this_field_first == ($past(field_odd) == $past(cmd_e[DOR_BIT_FIRST_FIELD]));
   endproperty
   a_field_first: assert property (p_field_first) else $error("first field wrong");

   property p_unused;
      pix_en && !pipe_out[2] |=> y_out == $past(unused_luma_code) && v_out == $past(unused_v_code);
   endproperty
   a_unused: assert property (p_unused) else $error("unused code missing");

   property p_invalid;
      pix_en && pipe_out[2] && !pipe_out[1] |=> y_out == $past(invalid_luma_code) && u_out == $past(invalid_u_code);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid code missing");

   property p_drop;
      pix_en && pipe_out[2] && !pipe_out[0] && output_command_f[DOR_BIT_INV_DROP] |=> v_out == $past(invalid_v_code);
   endproperty
   a_drop: assert property (p_drop) else $error("dropped line not invalid");

endmodule : dor_output_regs

// ### core/dor_pkg.sv
/*
 * Constants of the output command register bank of the video decoder:
 * register indices, field positions, reset values and pipeline timing.
 * Assumes an 8-bit register index space reached through the host link.
 */
package dor_pkg;

   // -----------------------------------------------------------------
   // Register indices
   // -----------------------------------------------------------------
   localparam logic [7:0] DOR_IDX_CMD_E       = 8'h3d;
   localparam logic [7:0] DOR_IDX_VSYNC_OFS   = 8'h3e;
   localparam logic [7:0] DOR_IDX_CMD_F       = 8'h3f;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int DOR_VSO_W            = 6;
   localparam int DOR_BIT_FIRST_FIELD  = 7;
   localparam int DOR_BIT_BW_BOOST     = 0;
   localparam int DOR_BIT_TASK_SEL     = 1;
   localparam int DOR_BIT_DEFERRED     = 2;
   localparam int DOR_BIT_DLY_PICK     = 3;
   localparam int DOR_BIT_DLY_EN       = 4;
   localparam int DOR_BIT_INV_DROP     = 5;
   localparam logic [7:0] DOR_CMD_F_MASK = 8'h3f;
   localparam logic [7:0] DOR_CMD_E_MASK = 8'h80;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] DOR_RST_CMD_E     = 8'h00;
   localparam logic [7:0] DOR_RST_VSYNC_OFS = 8'h00;
   localparam logic [7:0] DOR_RST_CMD_F     = 8'h00;
   localparam logic [7:0] DOR_READ_ZERO     = 8'h00;

   // -----------------------------------------------------------------
   // Registers updated at vertical sync when deferral is on
   // -----------------------------------------------------------------
   localparam logic [7:0] DOR_DEF_IDX_A     = 8'h02;
   localparam logic [7:0] DOR_DEF_IDX_LO    = 8'h17;
   localparam logic [7:0] DOR_DEF_IDX_HI    = 8'h1d;
   localparam logic [7:0] DOR_DEF_IDX_B     = 8'h04;
   localparam logic [7:0] DOR_DEF_MASK_B    = 8'h01;
   localparam logic [7:0] DOR_DEF_IDX_C     = 8'h0e;
   localparam logic [7:0] DOR_DEF_MASK_C    = 8'h77;
   localparam logic [7:0] DOR_MASK_ALL      = 8'hff;
   localparam logic [7:0] DOR_MASK_NONE     = 8'h00;

   // -----------------------------------------------------------------
   // Video pipeline
   // -----------------------------------------------------------------
   localparam int DOR_PIX_W       = 8;
   localparam int DOR_LINE_W      = 10;
   localparam int DOR_LATENCY_CK  = 120;
   localparam logic [9:0] DOR_LINE_ZERO = 10'h000;
   localparam logic [9:0] DOR_LINE_ONE  = 10'h001;

endpackage : dor_pkg

// ### core/dor_chroma_lag.sv
/*
 * One-sample lag on either chroma component.
 * Assumes pix_en marks each sample clock period in the clk domain.
 */
`timescale 1ns/1ps
module dor_chroma_lag
   import dor_pkg::*;
#(
   parameter int W = dor_pkg::DOR_PIX_W
)(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         pix_en,
   input  wire logic         lag_en,
   input  wire logic         lag_u,
   input  wire logic [W-1:0] u_in,
   input  wire logic [W-1:0] v_in,
   output logic      [W-1:0] u_out,
   output logic      [W-1:0] v_out
);

   logic [W-1:0] u_prev;
   logic [W-1:0] v_prev;

   // ----------------------------------------------------------------
   // Previous sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         u_prev <= '0;
         v_prev <= '0;
      end
      else if (pix_en)
      begin
         u_prev <= u_in;
         v_prev <= v_in;
      end
   end

   // ----------------------------------------------------------------
   // Lagged or direct component
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         u_out <= '0;
         v_out <= '0;
      end
      else if (pix_en)
      begin
         u_out <= (lag_en && lag_u) ? u_prev : u_in;
         v_out <= (lag_en && !lag_u) ? v_prev : v_in;
      end
   end

endmodule : dor_chroma_lag

// ### sim/dor_host_model.sv
/*
 * Host processor model: single-byte register writes and reads.
 * Assumes the bank takes a strobe at the rising clock edge.
 */
`timescale 1ns/1ps
module dor_host_model (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_idx,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic [7:0] write_now_mask
);
   logic [7:0] seen_mask;

   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_idx   = 8'h00;
      reg_wdata = 8'h00;
      seen_mask = 8'h00;
   end

   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   task automatic write(input logic [7:0] idx, input logic [7:0] data);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_idx   <= idx;
      reg_wdata <= data;
      @(negedge clk);
      seen_mask = write_now_mask;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~data;
   endtask : write

   task automatic read(input logic [7:0] idx, output logic [7:0] data);
      @(posedge clk);
      reg_rd  <= 1'b1;
      reg_idx <= idx;
      @(posedge clk);
      reg_rd  <= 1'b0;
      @(negedge clk);
      data = reg_rdata;
   endtask : read
endmodule : dor_host_model

// ### sim/dor_output_regs_test.sv
/*
 * Self-checking bench of the output command register bank.
 * Assumes a short pipeline parameter and the host model beside it.
 */
`timescale 1ns/1ps
module dor_output_regs_test;
   import dor_pkg::*;
   localparam int LAT = 4;
   logic       clk = 1'b0, rstn = 1'b0, vsp = 1'b0, evs = 1'b0, use_emb = 1'b0, dig = 1'b0;
   logic       lstart = 1'b0, fodd = 1'b0, vbi = 1'b0, pix_en = 1'b0, hact = 1'b0, shact = 1'b0, svact = 1'b0;
   logic [7:0] y_in = 8'h00, u_in = 8'h00, v_in = 8'h00, rd, mask, y_out, u_out, v_out;
   logic       wr, rdstb, apply, pend, bw, tbit, first;
   logic [7:0] idx, wdata, rdata;
   logic [9:0] lcnt;
   logic [7:0] inv_y = 8'h11;
   int         num_errors = 0, total_checks = 0;

   always #2 clk = ~clk;

   dor_host_model host_i (.clk(clk), .reg_wr(wr), .reg_rd(rdstb), .reg_idx(idx), .reg_wdata(wdata),
      .reg_rdata(rdata), .write_now_mask(mask));

   dor_output_regs #(.LATENCY(LAT)) dor_output_regs_i (.clk(clk), .rstn(rstn), .reg_wr(wr), .reg_rd(rdstb),
      .reg_idx(idx), .reg_wdata(wdata), .reg_rdata(rdata), .write_now_mask(mask), .deferred_apply(apply),
      .deferred_pending(pend), .vertical_sync_pin(vsp), .embedded_vsync(evs), .use_embedded_sync(use_emb),
      .digital_input_mode(dig), .line_start(lstart), .line_count(lcnt), .field_odd(fodd),
      .scale_this_field_first(first), .chroma_bw_boost(bw), .vbi_output(vbi), .task_bit(tbit),
      .pix_en(pix_en), .y_in(y_in), .u_in(u_in), .v_in(v_in), .horizontal_active(hact),
      .scaled_horizontal_active(shact), .scaled_vertical_active(svact), .invalid_luma_code(inv_y),
      .invalid_u_code(8'h12), .invalid_v_code(8'h13), .unused_luma_code(8'h21), .unused_u_code(8'h22),
      .unused_v_code(8'h23), .y_out(y_out), .u_out(u_out), .v_out(v_out));

   // ----------------------------------------------------------------
   // Comparison and closing
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic regs_access;
      host_i.read(DOR_IDX_CMD_F, rd);
      check("cmd_f reset", rd, DOR_RST_CMD_F);
      check("task reset", tbit, 1'b1);
      host_i.read(DOR_IDX_VSYNC_OFS, rd);
      check("ofs reset", rd, DOR_RST_VSYNC_OFS);
      host_i.write(DOR_IDX_VSYNC_OFS, 8'hff);
      host_i.read(DOR_IDX_VSYNC_OFS, rd);
      check("ofs rw", rd, 8'h3f);
      host_i.write(DOR_IDX_CMD_E, 8'hff);
      host_i.read(DOR_IDX_CMD_E, rd);
      check("cmd_e rw", rd, 8'h80);
      host_i.write(8'h50, 8'h5a);
      host_i.read(8'h50, rd);
      check("unmapped", rd, 8'h00);
      host_i.write(DOR_IDX_CMD_F, 8'hff);
      host_i.read(DOR_IDX_CMD_F, rd);
      check("cmd_f rw", rd, 8'h3f);
      check("bw on", bw, 1'b1);
      host_i.write(DOR_IDX_CMD_F, 8'h00);
      repeat (2) @(negedge clk);
      check("bw off", bw, 1'b0);
   endtask : regs_access

   task automatic task_code;
      for (int k = 0; k < 4; k++)
      begin
         host_i.write(DOR_IDX_CMD_F, {6'h00, k[1], 1'b0});
         vbi <= k[0];
         repeat (3) @(negedge clk);
         check("task bit", tbit, !(k[1] && k[0]));
      end
      vbi <= 1'b0;
   endtask : task_code

   task automatic field_first;
      for (int k = 0; k < 4; k++)
      begin
         host_i.write(DOR_IDX_CMD_E, {k[1], 7'h00});
         fodd <= k[0];
         repeat (3) @(negedge clk);
         check("first field", first, k[1] == k[0]);
      end
   endtask : field_first

   task automatic line_align(input logic mode, input logic [7:0] ofs);
      host_i.write(DOR_IDX_VSYNC_OFS, ofs);
      dig <= mode;
      repeat (3)
      begin
         @(posedge clk) lstart <= 1'b1;
         @(posedge clk) lstart <= 1'b0;
      end
      @(posedge clk) vsp <= 1'b1;
      for (int n = 0; n < 12 && lcnt !== {4'h0, ofs[5:0] & {6{mode}}}; n++)
         @(negedge clk);
      check("line count", lcnt, {4'h0, ofs[5:0] & {6{mode}}});
      repeat (8) @(posedge clk);
      vsp <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : line_align

   task automatic deferral;
      logic [7:0] tbl_idx[7] = '{8'h02, 8'h17, 8'h1d, 8'h04, 8'h0e, 8'h16, 8'h1e};
      logic [7:0] tbl_msk[7] = '{8'h00, 8'h00, 8'h00, 8'hfe, 8'h88, 8'hff, 8'hff};
      int         n;
      host_i.write(DOR_IDX_CMD_F, 8'h00);
      host_i.write(8'h02, 8'h55);
      check("mask off", host_i.seen_mask, 8'hff);
      check("pend off", pend, 1'b0);
      host_i.write(DOR_IDX_CMD_F, 8'h04);
      for (int k = 0; k < 7; k++)
      begin
         host_i.write(tbl_idx[k], 8'ha5);
         check("mask on", host_i.seen_mask, tbl_msk[k]);
      end
      @(negedge clk);
      check("pending", pend, 1'b1);
      @(posedge clk);
      use_emb <= 1'b1;
      evs     <= 1'b1;
      n = 0;
      while (apply !== 1'b1 && n < 12)
      begin
         @(negedge clk);
         n++;
      end
      check("apply", apply, 1'b1);
      @(negedge clk);
      check("pending clr", pend, 1'b0);
      @(posedge clk) evs <= 1'b0;
      use_emb <= 1'b0;
      host_i.write(DOR_IDX_CMD_F, 8'h00);
   endtask : deferral

   task automatic video(input logic [2:0] act, input logic [7:0] cmd, input int mode);
      logic [7:0] ey, eu, ev;
      host_i.write(DOR_IDX_CMD_F, cmd);
      inv_y <= 8'h11 ^ cmd;
      hact  <= act[2];
      shact <= act[1];
      svact <= act[0];
      for (int j = 0; j < 2 * LAT + 2; j++)
      begin
         @(posedge clk);
         pix_en <= 1'b1;
         y_in   <= 8'(j);
         u_in   <= 8'(8'h40 + j);
         v_in   <= 8'(8'h80 + j);
         @(posedge clk);
         pix_en <= 1'b0;
         @(negedge clk);
         if (j > LAT)
         begin
            ey = 8'(j - LAT + 1);
            eu = 8'(8'h40 + j - LAT + 1 - int'(cmd[4] && cmd[3]));
            ev = 8'(8'h80 + j - LAT + 1 - int'(cmd[4] && !cmd[3]));
            if (mode == 1)
               {ey, eu, ev} = {inv_y, 16'h1213};
            if (mode == 2)
               {ey, eu, ev} = 24'h212223;
            check("y_out", y_out, ey);
            check("u_out", u_out, eu);
            check("v_out", v_out, ev);
         end
      end
   endtask : video

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      regs_access();
      task_code();
      field_first();
      line_align(1'b1, 8'he5);
      line_align(1'b0, 8'h2a);
      deferral();
      video(3'b111, 8'h00, 0);
      video(3'b011, 8'h00, 2);
      video(3'b101, 8'h00, 1);
      video(3'b110, 8'h00, 0);
      video(3'b110, 8'h20, 1);
      video(3'b111, 8'h20, 0);
      video(3'b111, 8'h10, 0);
      video(3'b111, 8'h18, 0);
      video(3'b111, 8'h08, 0);
      report_and_stop();
   end

   initial
   begin
      #100us;
      num_errors++;
      report_and_stop();
   end
endmodule : dor_output_regs_test
